// ==== dv/rrie_exec_bench.sv ====
// self-checking bench for the return and rotate executor
`timescale 1ns/10ps
`include "rrie_defs.svh"
module rrie_exec_bench;
    import rrie_pkg::*;
    // ------------------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    rrie_byte_t src_data = 8'h00;
    logic call_push = 1'b0;
    rrie_addr_t call_addr = 15'h0000;
    logic int_enable_clear = 1'b0;
    logic ready, done, pc_load, carry, f_we;
    rrie_addr_t pc;
    rrie_byte_t w_reg, interrupt_control_reg, f_wdata;
    logic [6:0] f_addr;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    rrie_exec #(.STACK_DEPTH(16)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .src_data(src_data), .call_push(call_push), .call_addr(call_addr),
        .int_enable_clear(int_enable_clear), .ready(ready), .done(done), .pc_load(pc_load), .pc(pc),
        .w_reg(w_reg), .carry(carry), .interrupt_control_reg(interrupt_control_reg), .f_addr(f_addr),
        .f_wdata(f_wdata), .f_we(f_we));

    // ------------------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------------------
    initial forever #20 core_clk = ~core_clk;

    // the whole run needs well under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic push(input rrie_addr_t a);
        @(posedge core_clk);
        call_push <= 1'b1;
        call_addr <= a;
        @(posedge core_clk);
        call_push <= 1'b0;
    endtask

    // offers one word, counts edges from the take to done, checks the pulses
    task automatic run(input logic [13:0] word, input rrie_byte_t src, input int cyc, input logic pl,
                       input logic we);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_word <= word;
        src_data <= src;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        // the take edge itself is the first edge towards done
        #1 n = 1;
        if (cyc == 2) begin
            chk("ready while busy", 15'h0, ready);
            chk("done while busy", 15'h0, done);
        end
        while (done !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("done latency", 15'(cyc), 15'(n));
        chk("pc_load", pl, pc_load);
        chk("f_we", we, f_we);
        chk("ready at done", 15'h1, ready);
        @(posedge core_clk);
        #1 chk("done width", 15'h0, done);
        chk("pc_load width", 15'h0, pc_load);
        chk("f_we width", 15'h0, f_we);
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        repeat (3) @(posedge core_clk);
        #1 chk("reset ready", 15'h1, ready);
        chk("reset pc", `RRIE_PC_RESET, pc);
        chk("reset w", `RRIE_W_RESET, w_reg);
        chk("reset int control", 15'h0, interrupt_control_reg);
        chk("reset carry", 15'h0, carry);
        @(posedge core_clk);
        reset_n <= 1'b1;
    endtask

    task automatic t_rotate();
        run(14'h0d05, 8'he6, `RRIE_RLC_CYCLES, 1'b0, 1'b0);
        chk("rot w", 15'h00cc, w_reg);
        chk("rot carry", 15'h1, carry);
        // highest address, write back, carry in and a zero carry out
        run(14'h0dff, 8'h7f, `RRIE_RLC_CYCLES, 1'b0, 1'b1);
        chk("rot f_addr", 15'h007f, f_addr);
        chk("rot f_wdata", 15'h00ff, f_wdata);
        chk("rot carry out", 15'h0, carry);
        chk("rot w kept", 15'h00cc, w_reg);
        chk("rot int control kept", 15'h0, interrupt_control_reg);
        // two rotates on consecutive edges: the second must see the first's carry
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_word <= 14'h0d81;
        src_data <= 8'h80;
        @(posedge core_clk);
        instr_word <= 14'h0d02;
        src_data <= 8'h01;
        #1 chk("pair f_wdata", 15'h0000, f_wdata);
        chk("pair f_addr", 15'h0001, f_addr);
        chk("pair carry", 15'h1, carry);
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1 chk("pair w", 15'h0003, w_reg);
        chk("pair carry out", 15'h0, carry);
        chk("pair done", 15'h1, done);
        chk("pair f_we", 15'h0, f_we);
    endtask

    task automatic t_returns();
        push(15'h1234);
        push(15'h7abc);
        run(`RRIE_IRET_CODE, 8'h00, `RRIE_RET_CYCLES, 1'b1, 1'b0);
        chk("iret pc", 15'h7abc, pc);
        chk("iret enable", 15'h0080, interrupt_control_reg);
        @(posedge core_clk);
        int_enable_clear <= 1'b1;
        @(posedge core_clk);
        int_enable_clear <= 1'b0;
        #1 chk("enable cleared", 15'h0, interrupt_control_reg);
        run(14'h34ff, 8'h00, `RRIE_RET_CYCLES, 1'b1, 1'b0);
        chk("lret pc", 15'h1234, pc);
        chk("lret w", 15'h00ff, w_reg);
        chk("lret int control", 15'h0, interrupt_control_reg);
        push(15'h7fff);
        push(15'h0155);
        run(`RRIE_RETURN_CODE, 8'h00, `RRIE_RET_CYCLES, 1'b1, 1'b0);
        chk("ret pc", 15'h0155, pc);
        // second return by hand, with a rotate offered while it is busy
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_word <= `RRIE_RETURN_CODE;
        @(posedge core_clk);
        instr_word <= 14'h0d00;
        src_data <= 8'hff;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1 chk("ret2 done", 15'h1, done);
        chk("ret2 pc", 15'h7fff, pc);
        chk("ret2 pc_load", 15'h1, pc_load);
        @(posedge core_clk);
        #1 chk("busy rotate done", 15'h0, done);
        chk("busy rotate carry", 15'h0, carry);
        chk("ret w kept", 15'h00ff, w_reg);
        chk("ret int control kept", 15'h0, interrupt_control_reg);
    endtask

    initial begin
        t_reset();
        t_rotate();
        t_returns();
        finish_test();
    end
endmodule // rrie_exec_bench

// ==== src/rrie_defs.svh ====
// constants for the return and rotate execution block
`ifndef RRIE_DEFS_SVH
`define RRIE_DEFS_SVH

// ----------------------------------------------------------------------------
// instruction encodings (14-bit program word)
// ----------------------------------------------------------------------------
`define RRIE_RETURN_CODE 14'h0008
`define RRIE_IRET_CODE 14'h0009
`define RRIE_LRET_MASK 14'h3f00
`define RRIE_LRET_CODE 14'h3400
`define RRIE_RLC_MASK 14'h3f00
`define RRIE_RLC_CODE 14'h0d00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RRIE_DEST_BIT 7
`define RRIE_FADDR_MSB 6
`define RRIE_LIT_MSB 7
`define RRIE_INT_EN_BIT 7

// ----------------------------------------------------------------------------
// timing counts, in instruction cycles
// ----------------------------------------------------------------------------
`define RRIE_RET_CYCLES 2
`define RRIE_RLC_CYCLES 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RRIE_PC_RESET 15'h0000
`define RRIE_W_RESET 8'h00
`define RRIE_SP_RESET 4'h0

`endif

// ==== src/rrie_exec.sv ====
// executor for interrupt return, literal return, subroutine return and rotate left
`timescale 1ns/10ps
`include "rrie_defs.svh"

module rrie_exec #(
    parameter int STACK_DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire rrie_pkg::rrie_byte_t src_data,
    input wire logic call_push,
    input wire rrie_pkg::rrie_addr_t call_addr,
    input wire logic int_enable_clear,
    output logic ready,
    output logic done,
    output logic pc_load,
    output rrie_pkg::rrie_addr_t pc,
    output rrie_pkg::rrie_byte_t w_reg,
    output logic carry,
    output rrie_pkg::rrie_byte_t interrupt_control_reg,
    output logic [6:0] f_addr,
    output rrie_pkg::rrie_byte_t f_wdata,
    output logic f_we
);
    import rrie_pkg::*;

    typedef struct packed {
        rrie_state_t state;
        rrie_op_t op;
        logic [7:0] lit;
        logic ready;
        logic done;
        logic pc_load;
        rrie_addr_t pc;
        logic [7:0] w;
        logic carry;
        logic [7:0] int_ctrl;
        logic [6:0] f_addr;
        logic [7:0] f_wdata;
        logic f_we;
    } rrie_exec_st_t;

    rrie_exec_st_t s;
    rrie_exec_st_t next_s;
    rrie_stack_if sif ();

    logic take;
    logic take_ret;
    logic take_iret;
    logic take_lret;
    logic take_rlc;
    logic [7:0] rlc_result;

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    assign take = instr_valid && s.ready;
    assign take_ret = take && (instr_word == `RRIE_RETURN_CODE);
    assign take_iret = take && (instr_word == `RRIE_IRET_CODE);
    assign take_lret = take && ((instr_word & `RRIE_LRET_MASK) == `RRIE_LRET_CODE);
    assign take_rlc = take && ((instr_word & `RRIE_RLC_MASK) == `RRIE_RLC_CODE);
    assign rlc_result = {src_data[6:0], s.carry};

    // calls from the rest of the core fill the stack; a pop always wins
    // the port, which it uses only in the cycle a return is taken
    assign sif.push = call_push && !sif.pop;
    assign sif.push_data = call_addr;
    assign sif.pop = take_ret || take_iret || take_lret;

    rrie_stack #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sif(sif)
    );

    // ------------------------------------------------------------------------
    // execution state machine
    // ------------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.pc_load = 1'b0;
        next_s.f_we = 1'b0;
        if (int_enable_clear) begin
            next_s.int_ctrl[`RRIE_INT_EN_BIT] = 1'b0;
        end
        case (s.state)
            RRIE_IDLE: begin
                if (take_rlc) begin
                    // only carry is touched among the flags
                    next_s.carry = src_data[7];
                    next_s.done = 1'b1;
                    if (instr_word[`RRIE_DEST_BIT]) begin
                        next_s.f_we = 1'b1;
                        next_s.f_addr = instr_word[`RRIE_FADDR_MSB:0];
                        next_s.f_wdata = rlc_result;
                    end else begin
                        next_s.w = rlc_result;
                    end
                end else if (sif.pop) begin
                    next_s.ready = 1'b0;
                    next_s.state = RRIE_FINISH;
                    next_s.lit = instr_word[`RRIE_LIT_MSB:0];
                    if (take_iret) begin
                        next_s.op = RRIE_OP_IRET;
                    end else if (take_lret) begin
                        next_s.op = RRIE_OP_LRET;
                    end else begin
                        next_s.op = RRIE_OP_RETURN;
                    end
                end
            end
            RRIE_FINISH: begin
                // the head register already holds the popped entry, so the
                // second cycle needs no wait state of its own
                next_s.pc = sif.head;
                next_s.pc_load = 1'b1;
                next_s.done = 1'b1;
                next_s.ready = 1'b1;
                next_s.state = RRIE_IDLE;
                if (s.op == RRIE_OP_IRET) begin
                    // after the clear above, so a set in the same cycle wins
                    next_s.int_ctrl[`RRIE_INT_EN_BIT] = 1'b1;
                end
                if (s.op == RRIE_OP_LRET) begin
                    next_s.w = s.lit;
                end
            end
            default: begin
                next_s.state = RRIE_IDLE;
                next_s.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.state <= RRIE_IDLE;
            s.op <= RRIE_OP_RETURN;
            s.ready <= 1'b1;
            s.pc <= `RRIE_PC_RESET;
            s.w <= `RRIE_W_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign ready = s.ready;
    assign done = s.done;
    assign pc_load = s.pc_load;
    assign pc = s.pc;
    assign w_reg = s.w;
    assign carry = s.carry;
    assign interrupt_control_reg = s.int_ctrl;
    assign f_addr = s.f_addr;
    assign f_wdata = s.f_wdata;
    assign f_we = s.f_we;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_iret_pc;
        rrie_addr_t h;
        take_iret ##1 (1'b1, h = sif.head) |-> ##1 (pc_load && pc == h);
    endproperty
    a_iret_pc: assert property (p_iret_pc) else $error("interrupt return pc wrong");

    property p_iret_enable;
        take_iret ##1 1'b1 |=> interrupt_control_reg[`RRIE_INT_EN_BIT];
    endproperty
    a_iret_enable: assert property (p_iret_enable) else $error("enable bit not set");

    property p_iret_two;
        take_iret |=> !done ##1 done;
    endproperty
    a_iret_two: assert property (p_iret_two) else $error("interrupt return not two cycles");

    property p_lret_w;
        take_lret |-> ##2 (w_reg == $past(instr_word[7:0], 2));
    endproperty
    a_lret_w: assert property (p_lret_w) else $error("literal not loaded");

    property p_lret_pc;
        take_lret |=> !pc_load && !ready ##1 (pc_load && done && pc == $past(sif.head));
    endproperty
    a_lret_pc: assert property (p_lret_pc) else $error("literal return pc wrong");

    property p_ret_pc;
        take_ret |-> ##2 (pc_load && pc == $past(sif.head) && $stable(w_reg) && $stable(interrupt_control_reg));
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("subroutine return wrong");

    property p_rlc_bits;
        take_rlc |=> (carry == $past(src_data[7])) && (f_we ? f_wdata : w_reg) == {$past(src_data[6:0]), $past(carry)};
    endproperty
    a_rlc_bits: assert property (p_rlc_bits) else $error("rotate result wrong");

    property p_rlc_dest;
        take_rlc |=> (f_we == $past(instr_word[7])) && (f_we ? $stable(w_reg) : 1'b1);
    endproperty
    a_rlc_dest: assert property (p_rlc_dest) else $error("rotate destination wrong");

    property p_rlc_one;
        take_rlc |=> done && ready && !pc_load && (!f_we || f_addr == $past(instr_word[6:0]));
    endproperty
    a_rlc_one: assert property (p_rlc_one) else $error("rotate not single cycle");

    c_iret: cover property (take_iret ##2 done);
    c_lret: cover property (take_lret ##2 done);
    c_rlc_file: cover property (take_rlc && instr_word[7] ##1 take_rlc);
    c_ret: cover property (take_ret ##2 pc_load);
endmodule // rrie_exec

// ==== src/rrie_pkg.sv ====
// types shared by the return and rotate execution block
package rrie_pkg;
    typedef enum logic [1:0] {
        RRIE_IDLE,
        RRIE_FINISH
    } rrie_state_t;

    typedef enum logic [1:0] {
        RRIE_OP_RETURN,
        RRIE_OP_IRET,
        RRIE_OP_LRET
    } rrie_op_t;

    typedef logic [14:0] rrie_addr_t;
    typedef logic [7:0] rrie_byte_t;
endpackage

// ==== src/rrie_stack.sv ====
// hardware return stack with a registered head entry
`timescale 1ns/10ps
`include "rrie_defs.svh"
module rrie_stack #(
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    rrie_stack_if.stack sif
);
    import rrie_pkg::*;

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][14:0] mem;
        logic [PW-1:0] sp;
        rrie_addr_t head;
    } rrie_stk_t;

    rrie_stk_t s;
    rrie_stk_t next_s;

    // pointer wraps on overflow and underflow, as a circular stack does
    always_comb begin
        next_s = s;
        if (sif.push) begin
            next_s.mem[s.sp] = sif.push_data;
            next_s.sp = s.sp + 1'b1;
            next_s.head = sif.push_data;
        end else if (sif.pop) begin
            next_s.sp = s.sp - 1'b1;
            next_s.head = s.mem[s.sp - 1'b1];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sif.head = s.head;
endmodule // rrie_stack

// ==== src/rrie_stack_if.sv ====
// link between the executor and the return stack
`timescale 1ns/10ps
interface rrie_stack_if;
    import rrie_pkg::*;
    logic push;
    rrie_addr_t push_data;
    logic pop;
    rrie_addr_t head;

    modport exec (output push, output push_data, output pop, input head);
    modport stack (input push, input push_data, input pop, output head);
endinterface // rrie_stack_if
